// ### src/adc_path_config.sv
/*
 * Configuration registers and datapath of the converter digital back end:
 * averaging, input mux, mixer with decimation, scrambler, serial output.
 * Assumes an APB master on ref_clk_i and a converter sample clock pin that
 * runs well below ref_clk_i; the 50 ps trims drive external delay cells.
 */
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
module adc_path_config #(
    parameter int SAMPLE_W = 18
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [adc_path_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Converter side
    input wire logic sample_clk_i,
    input wire logic [SAMPLE_W-1:0] sample_a_i,
    input wire logic [SAMPLE_W-1:0] sample_b_i,
    // Serial output
    output logic output_bit_clock_o,
    output logic frame_clock_o,
    output logic lane_a_o,
    output logic lane_b_o,
    output logic [1:0] data_timing_trim_o,
    output logic [1:0] bit_clock_timing_trim_o
);
    import adc_path_pkg::*;

    localparam int ACC_W = SAMPLE_W + 6;

    function automatic logic [SAMPLE_W-1:0] cond_neg(input logic [SAMPLE_W-1:0] x, input logic neg);
        cond_neg = neg ? SAMPLE_W'(-x) : x;
    endfunction

    function automatic logic [ACC_W-1:0] sext(input logic [SAMPLE_W-1:0] x);
        sext = {{(ACC_W-SAMPLE_W){x[SAMPLE_W-1]}}, x};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] trim_ff;
    logic [7:0] frame_low_ff;
    logic [7:0] frame_mid_ff;
    logic [7:0] frame_high_ff;
    logic [7:0] path_ctrl_ff;
    logic [7:0] decim_ctrl_ff;
    logic [31:0] nco_freq_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;

    wire [7:0] reg_idx = paddr_i[ADDR_W-1:2];
    wire word_ok = (paddr_i[1:0] == 2'h0);
    wire hit_trim = word_ok && (reg_idx == IDX_TIMING_TRIM);
    wire hit_low = word_ok && (reg_idx == IDX_FRAME_LOW);
    wire hit_mid = word_ok && (reg_idx == IDX_FRAME_MID);
    wire hit_high = word_ok && (reg_idx == IDX_FRAME_HIGH);
    wire hit_path = word_ok && (reg_idx == IDX_PATH_CTRL);
    wire hit_decim = word_ok && (reg_idx == IDX_DECIM_CTRL);
    wire hit_nco = word_ok && (reg_idx == IDX_NCO_FREQ);
    wire hit_any = hit_trim | hit_low | hit_mid | hit_high | hit_path | hit_decim | hit_nco;
    wire setup_phase = psel_i && !penable_i;
    wire wr_commit = psel_i && penable_i && pready_ff && pwrite_i && !pslverr_ff;
    wire [31:0] nxt_prdata =
        hit_trim ? {24'h0, trim_ff} :
        hit_low ? {24'h0, frame_low_ff} :
        hit_mid ? {24'h0, frame_mid_ff} :
        hit_high ? {24'h0, frame_high_ff} :
        hit_path ? {24'h0, path_ctrl_ff} :
        hit_decim ? {24'h0, decim_ctrl_ff} :
        hit_nco ? nco_freq_ff : 32'h0000_0000;

    // Answer is registered in setup, so every access completes in one access cycle
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else if (setup_phase) begin
            pready_ff <= 1'b1;
            pslverr_ff <= !hit_any;
            prdata_ff <= pwrite_i ? 32'h0000_0000 : nxt_prdata;
        end else begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            trim_ff <= TIMING_TRIM_RESET;
            frame_low_ff <= FRAME_PATTERN_RESET[7:0];
            frame_mid_ff <= FRAME_PATTERN_RESET[15:8];
            frame_high_ff <= {4'h0, FRAME_PATTERN_RESET[19:16]};
            path_ctrl_ff <= PATH_CTRL_RESET;
            decim_ctrl_ff <= DECIM_CTRL_RESET;
            nco_freq_ff <= NCO_FREQ_RESET;
        end else if (wr_commit) begin
            // Reserved bits are masked so they always read zero
            if (hit_trim) trim_ff <= pwdata_i[7:0] & MASK_TIMING_TRIM;
            if (hit_low) frame_low_ff <= pwdata_i[7:0];
            if (hit_mid) frame_mid_ff <= pwdata_i[7:0];
            if (hit_high) frame_high_ff <= pwdata_i[7:0] & MASK_FRAME_HIGH;
            if (hit_path) path_ctrl_ff <= pwdata_i[7:0] & MASK_PATH_CTRL;
            if (hit_decim) decim_ctrl_ff <= pwdata_i[7:0] & MASK_DECIM_CTRL;
            if (hit_nco) nco_freq_ff <= pwdata_i;
        end
    end

    assign prdata_o = prdata_ff;
    assign pready_o = pready_ff;
    assign pslverr_o = pslverr_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Field decode
    wire [19:0] frame_pattern = {frame_high_ff[3:0], frame_mid_ff, frame_low_ff};
    wire scrambler_enable = frame_high_ff[POS_SCRAMBLE];
    wire channel_average_enable = path_ctrl_ff[POS_AVG_EN];
    wire [1:0] downconverter_input_select = path_ctrl_ff[POS_MUX_SEL +: 2];
    wire digital_feature_path_select = path_ctrl_ff[POS_DIG_PATH];
    wire downconverter_enable = path_ctrl_ff[POS_DOWNCONVERTER_ENABLE];
    wire downconverter_input_mux_enable = decim_ctrl_ff[POS_MUX_EN];
    wire [2:0] decim_code = decim_ctrl_ff[POS_DECIM +: 3];
    wire real_out = decim_ctrl_ff[POS_REAL_OUT];
    wire mix_phase = decim_ctrl_ff[POS_MIX_PHASE];
    // Unused ratio codes fall back to bypass
    wire [2:0] decim_ratio = (decim_code > DECIM_MAX) ? DECIM_BYPASS : decim_code;
    wire decimating = digital_feature_path_select && downconverter_enable
        && (decim_ratio != DECIM_BYPASS);
    wire [31:0] nco_word = real_out ? 32'h0000_0000 : nco_freq_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Sample clock and data synchronisers
    logic [2:0] sclk_sync_ff;
    logic [SAMPLE_W-1:0] a_meta_ff;
    logic [SAMPLE_W-1:0] a_sync_ff;
    logic [SAMPLE_W-1:0] b_meta_ff;
    logic [SAMPLE_W-1:0] b_sync_ff;

    always_ff @(posedge ref_clk_i) begin
        sclk_sync_ff <= {sclk_sync_ff[1:0], sample_clk_i};
        a_meta_ff <= sample_a_i;
        a_sync_ff <= a_meta_ff;
        b_meta_ff <= sample_b_i;
        b_sync_ff <= b_meta_ff;
    end

    // Data settles a full sample period before the edge is seen
    wire sample_stb = sclk_sync_ff[1] && !sclk_sync_ff[2];

    ////////////////////////////////////////////////////////////////////////////
    // Averaging, mux, mixer, decimator
    wire [SAMPLE_W:0] sum_ab = {a_sync_ff[SAMPLE_W-1], a_sync_ff} + {b_sync_ff[SAMPLE_W-1], b_sync_ff};
    wire [SAMPLE_W-1:0] avg_ab = sum_ab[SAMPLE_W:1];
    wire avg_active = channel_average_enable && digital_feature_path_select;
    wire mux_active = downconverter_input_mux_enable && digital_feature_path_select;
    wire [SAMPLE_W-1:0] mux_a =
        !mux_active ? a_sync_ff :
        (downconverter_input_select == MUX_B_BOTH) ? b_sync_ff :
        (downconverter_input_select == MUX_AVG_BOTH) ? (avg_active ? avg_ab : a_sync_ff) :
        a_sync_ff;
    wire [SAMPLE_W-1:0] mux_b =
        !mux_active ? b_sync_ff :
        (downconverter_input_select == MUX_A_BOTH) ? a_sync_ff :
        (downconverter_input_select == MUX_AVG_BOTH) ? (avg_active ? avg_ab : b_sync_ff) :
        b_sync_ff;

    logic [31:0] phase_ff;
    wire [31:0] phase_used = mix_phase ? ~phase_ff : phase_ff;
    wire cos_neg = phase_used[31] ^ phase_used[30];
    wire sin_neg = phase_used[31];
    // Real mode skips the mixer on the I paths, complex mode uses a square-wave oscillator
    wire [SAMPLE_W-1:0] mix_ai = real_out ? mux_a : cond_neg(mux_a, cos_neg);
    wire [SAMPLE_W-1:0] mix_aq = cond_neg(mux_a, sin_neg);
    wire [SAMPLE_W-1:0] mix_bi = real_out ? mux_b : cond_neg(mux_b, cos_neg);
    wire [SAMPLE_W-1:0] mix_bq = cond_neg(mux_b, sin_neg);

    logic [4:0] dec_cnt_ff;
    logic [ACC_W-1:0] acc_ai_ff;
    logic [ACC_W-1:0] acc_aq_ff;
    logic [ACC_W-1:0] acc_bi_ff;
    logic [ACC_W-1:0] acc_bq_ff;
    logic [SAMPLE_W-1:0] res_ai_ff;
    logic [SAMPLE_W-1:0] res_aq_ff;
    logic [SAMPLE_W-1:0] res_bi_ff;
    logic [SAMPLE_W-1:0] res_bq_ff;

    wire [4:0] dec_last = 5'((6'h01 << decim_ratio) - 6'h01);
    wire dump = (dec_cnt_ff == dec_last);
    wire [ACC_W-1:0] nxt_ai = acc_ai_ff + sext(mix_ai);
    wire [ACC_W-1:0] nxt_aq = acc_aq_ff + sext(mix_aq);
    wire [ACC_W-1:0] nxt_bi = acc_bi_ff + sext(mix_bi);
    wire [ACC_W-1:0] nxt_bq = acc_bq_ff + sext(mix_bq);
    wire [ACC_W-1:0] avg_ai = $signed(nxt_ai) >>> decim_ratio;
    wire [ACC_W-1:0] avg_aq = $signed(nxt_aq) >>> decim_ratio;
    wire [ACC_W-1:0] avg_bi = $signed(nxt_bi) >>> decim_ratio;
    wire [ACC_W-1:0] avg_bq = $signed(nxt_bq) >>> decim_ratio;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            phase_ff <= 32'h0000_0000;
            dec_cnt_ff <= 5'h00;
            acc_ai_ff <= '0;
            acc_aq_ff <= '0;
            acc_bi_ff <= '0;
            acc_bq_ff <= '0;
            res_ai_ff <= '0;
            res_aq_ff <= '0;
            res_bi_ff <= '0;
            res_bq_ff <= '0;
        end else if (sample_stb) begin
            phase_ff <= phase_ff + nco_word;
            if (!decimating) begin
                // Full-rate path: bypass or downconverter off
                dec_cnt_ff <= 5'h00;
                res_ai_ff <= digital_feature_path_select ? mix_ai : a_sync_ff;
                res_bi_ff <= digital_feature_path_select ? mix_bi : b_sync_ff;
                res_aq_ff <= mix_aq;
                res_bq_ff <= mix_bq;
            end else if (dump) begin
                dec_cnt_ff <= 5'h00;
                acc_ai_ff <= '0;
                acc_aq_ff <= '0;
                acc_bi_ff <= '0;
                acc_bq_ff <= '0;
                res_ai_ff <= avg_ai[SAMPLE_W-1:0];
                res_aq_ff <= avg_aq[SAMPLE_W-1:0];
                res_bi_ff <= avg_bi[SAMPLE_W-1:0];
                res_bq_ff <= avg_bq[SAMPLE_W-1:0];
            end else begin
                dec_cnt_ff <= dec_cnt_ff + 5'h01;
                acc_ai_ff <= nxt_ai;
                acc_aq_ff <= nxt_aq;
                acc_bi_ff <= nxt_bi;
                acc_bq_ff <= nxt_bq;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bit clock divider, scrambler and serializer
    logic [7:0] half_cnt_ff;
    logic bit_clk_ff;
    logic [4:0] bit_cnt_ff;
    logic q_slot_ff;
    logic [14:0] lfsr_ff;
    logic [WORD_W-1:0] shift_a_ff;
    logic [WORD_W-1:0] shift_b_ff;
    logic [19:0] frame_shift_ff;
    logic frame_ff;
    logic lane_a_ff;
    logic lane_b_ff;

    wire half_tick = (half_cnt_ff == 8'(BIT_HALF_CYCLES - 1));
    wire bit_stb = half_tick && bit_clk_ff;
    wire word_start = (bit_cnt_ff == 5'h00);
    wire complex_out = decimating && !real_out;
    // Complex mode alternates I and Q words on each lane
    wire [SAMPLE_W-1:0] word_a = (complex_out && q_slot_ff) ? res_aq_ff : res_ai_ff;
    wire [SAMPLE_W-1:0] word_b = (complex_out && q_slot_ff) ? res_bq_ff : res_bi_ff;
    wire scramble_on = scrambler_enable && digital_feature_path_select;
    wire [WORD_W-1:0] scr_mask = scramble_on ? {5'h00, lfsr_ff} : '0;
    // Bypass ignores the programmed pattern
    wire [19:0] frame_sel = digital_feature_path_select && decimating
        ? frame_pattern : FRAME_PATTERN_AUTO;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            half_cnt_ff <= 8'h00;
            bit_clk_ff <= 1'b0;
        end else if (half_tick) begin
            half_cnt_ff <= 8'h00;
            bit_clk_ff <= !bit_clk_ff;
        end else begin
            half_cnt_ff <= half_cnt_ff + 8'h01;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            bit_cnt_ff <= 5'h00;
            q_slot_ff <= 1'b0;
            lfsr_ff <= 15'h7FFF;
            shift_a_ff <= '0;
            shift_b_ff <= '0;
            frame_shift_ff <= 20'h00000;
            frame_ff <= 1'b0;
            lane_a_ff <= 1'b0;
            lane_b_ff <= 1'b0;
        end else if (bit_stb) begin
            bit_cnt_ff <= (bit_cnt_ff == 5'(WORD_W - 1)) ? 5'h00 : bit_cnt_ff + 5'h01;
            if (word_start) begin
                q_slot_ff <= !q_slot_ff;
                lfsr_ff <= {lfsr_ff[13:0], lfsr_ff[14] ^ lfsr_ff[13]};
                shift_a_ff <= {word_a, 2'b00} ^ scr_mask;
                shift_b_ff <= {word_b, 2'b00} ^ scr_mask;
                frame_shift_ff <= {frame_sel[18:0], 1'b0};
                frame_ff <= frame_sel[19];
                lane_a_ff <= word_a[SAMPLE_W-1] ^ scr_mask[WORD_W-1];
                lane_b_ff <= word_b[SAMPLE_W-1] ^ scr_mask[WORD_W-1];
            end else begin
                frame_ff <= frame_shift_ff[19];
                frame_shift_ff <= {frame_shift_ff[18:0], 1'b0};
                lane_a_ff <= shift_a_ff[WORD_W-2];
                lane_b_ff <= shift_b_ff[WORD_W-2];
                shift_a_ff <= {shift_a_ff[WORD_W-2:0], 1'b0};
                shift_b_ff <= {shift_b_ff[WORD_W-2:0], 1'b0};
            end
        end
    end

    assign output_bit_clock_o = bit_clk_ff;
    assign frame_clock_o = frame_ff;
    assign lane_a_o = lane_a_ff;
    assign lane_b_o = lane_b_ff;
    // Sub-cycle trims go to pad delay cells
    assign data_timing_trim_o = trim_ff[POS_DATA_TRIM +: 2];
    assign bit_clock_timing_trim_o = trim_ff[POS_CLK_TRIM +: 2];
endmodule

// ### src/adc_path_pkg.sv
/*
 * Shared constants for the converter digital back-end configuration block:
 * register indices, field positions, reset values and timing counts.
 * Assumes an APB master with 32-bit data; byte address is four times the index.
 */
package adc_path_pkg;
    // Register indices (byte address = index * 4)
    localparam logic [7:0] IDX_TIMING_TRIM = 8'h1E;
    localparam logic [7:0] IDX_FRAME_LOW = 8'h20;
    localparam logic [7:0] IDX_FRAME_MID = 8'h21;
    localparam logic [7:0] IDX_FRAME_HIGH = 8'h22;
    localparam logic [7:0] IDX_PATH_CTRL = 8'h24;
    localparam logic [7:0] IDX_DECIM_CTRL = 8'h25;
    localparam logic [7:0] IDX_NCO_FREQ = 8'h30;
    localparam int ADDR_W = 10;

    // Writable bit masks; reserved bits stay zero
    localparam logic [7:0] MASK_TIMING_TRIM = 8'h0F;
    localparam logic [7:0] MASK_FRAME_HIGH = 8'h4F;
    localparam logic [7:0] MASK_PATH_CTRL = 8'h3E;
    localparam logic [7:0] MASK_DECIM_CTRL = 8'hF9;

    // Reset values
    localparam logic [19:0] FRAME_PATTERN_RESET = 20'hFFC00;
    localparam logic [7:0] TIMING_TRIM_RESET = 8'h00;
    localparam logic [7:0] PATH_CTRL_RESET = 8'h00;
    localparam logic [7:0] DECIM_CTRL_RESET = 8'h00;
    localparam logic [31:0] NCO_FREQ_RESET = 32'h0000_0000;

    // Field positions
    localparam int POS_DATA_TRIM = 2;
    localparam int POS_CLK_TRIM = 0;
    localparam int POS_SCRAMBLE = 6;
    localparam int POS_AVG_EN = 5;
    localparam int POS_MUX_SEL = 3;
    localparam int POS_DIG_PATH = 2;
    localparam int POS_DOWNCONVERTER_ENABLE = 1;
    localparam int POS_MUX_EN = 7;
    localparam int POS_DECIM = 4;
    localparam int POS_REAL_OUT = 3;
    localparam int POS_MIX_PHASE = 0;

    // Input mux codes
    localparam logic [1:0] MUX_STRAIGHT = 2'h0;
    localparam logic [1:0] MUX_A_BOTH = 2'h1;
    localparam logic [1:0] MUX_B_BOTH = 2'h2;
    localparam logic [1:0] MUX_AVG_BOTH = 2'h3;

    // Decimation codes; 000 bypass, 101 the largest legal ratio
    localparam logic [2:0] DECIM_BYPASS = 3'h0;
    localparam logic [2:0] DECIM_MAX = 3'h5;

    // Serial word and automatic frame pattern used when decimation is bypassed
    localparam int WORD_W = 20;
    localparam logic [19:0] FRAME_PATTERN_AUTO = 20'hFFC00;

    // Bit period of the serial link
    localparam int CLK_PERIOD_PS = 5000;
    localparam int BIT_HALF_PS = 10000;
    localparam int BIT_HALF_CYCLES = (BIT_HALF_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage

// ### tb/adc_path_sva.sv
/* Port checker for the back-end configuration block.
   Assumes it is bound to adc_path_config, one clock domain on ref_clk_i. */
`timescale 1ns/100ps
module adc_path_sva
    import adc_path_pkg::*;
(
    // Clock, reset and APB
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [adc_path_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Serial side
    input wire logic output_bit_clock_o,
    input wire logic lane_a_o,
    input wire logic [1:0] data_timing_trim_o,
    input wire logic [1:0] bit_clock_timing_trim_o
);
    wire logic [7:0] idx = paddr_i[9:2];
    wire logic hit = idx == IDX_TIMING_TRIM || idx == IDX_FRAME_LOW || idx == IDX_FRAME_MID
        || idx == IDX_FRAME_HIGH || idx == IDX_PATH_CTRL || idx == IDX_DECIM_CTRL || idx == IDX_NCO_FREQ;
    wire logic mapped = hit && paddr_i[1:0] == 2'h0;
    wire logic trim_wr = psel_i && penable_i && pready_o && pwrite_i && mapped && idx == IDX_TIMING_TRIM;
    wire logic [1:0] wr_dtrim = pwdata_i[3:2];
    wire logic [1:0] wr_ctrim = pwdata_i[1:0];
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    sequence s_setup; psel_i && !penable_i; endsequence
    sequence s_access; s_setup ##1 (psel_i && penable_i && pready_o); endsequence
    property p_ready; s_setup |=> pready_o; endproperty
    property p_err_map; s_access |-> pslverr_o == !mapped; endproperty
    property p_err_data; pready_o && pslverr_o |-> prdata_o == 32'h0; endproperty
    property p_rd_high; s_access ##0 (!pwrite_i && idx != IDX_NCO_FREQ) |-> prdata_o[31:8] == 24'h0; endproperty
    property p_trim_wr; trim_wr |=> data_timing_trim_o == $past(wr_dtrim) && bit_clock_timing_trim_o == $past(wr_ctrim); endproperty
    property p_trim_hold; !trim_wr |=> $stable(data_timing_trim_o) && $stable(bit_clock_timing_trim_o); endproperty
    property p_bclk_hi; $rose(output_bit_clock_o) |=> output_bit_clock_o ##1 !output_bit_clock_o; endproperty
    property p_bclk_lo; $fell(output_bit_clock_o) |=> !output_bit_clock_o ##1 output_bit_clock_o; endproperty
    property p_lane_edge; $changed(lane_a_o) |-> $fell(output_bit_clock_o); endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    a_err_map: assert property (p_err_map) else $error("error flag wrong for address");
    a_err_data: assert property (p_err_data) else $error("refused transfer returned data");
    a_rd_high: assert property (p_rd_high) else $error("upper read bits not zero");
    a_trim_wr: assert property (p_trim_wr) else $error("trim outputs not written");
    a_trim_hold: assert property (p_trim_hold) else $error("trim outputs moved");
    a_bclk_hi: assert property (p_bclk_hi) else $error("bit clock high phase wrong");
    a_bclk_lo: assert property (p_bclk_lo) else $error("bit clock low phase wrong");
    a_lane_edge: assert property (p_lane_edge) else $error("lane moved off bit clock fall");
endmodule

bind adc_path_config adc_path_sva u_adc_path_sva (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .output_bit_clock_o(output_bit_clock_o), .lane_a_o(lane_a_o),
    .data_timing_trim_o(data_timing_trim_o), .bit_clock_timing_trim_o(bit_clock_timing_trim_o));

// ### tb/lvds_receiver.sv
/* Logic receiver on the serial output: deserialises frame and both lanes.
   Assumes bit clock far slower than ref_clk_i; data stable at its rise. */
`timescale 1ns/100ps
module lvds_receiver (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Serial lines
    input wire logic bit_clock_i,
    input wire logic frame_i,
    input wire logic lane_a_i,
    input wire logic lane_b_i,
    // Last 20 bits seen
    output logic [19:0] frame_word_o,
    output logic [19:0] lane_a_word_o,
    output logic [19:0] lane_b_word_o
);
    logic bclk_ff;
    // Sampled one cycle after the rise, well inside the stable half period
    always_ff @(posedge ref_clk_i) begin
        bclk_ff <= reset_i ? 1'b0 : bit_clock_i;
        if (!reset_i && bit_clock_i && !bclk_ff) begin
            frame_word_o <= {frame_word_o[18:0], frame_i};
            lane_a_word_o <= {lane_a_word_o[18:0], lane_a_i};
            lane_b_word_o <= {lane_b_word_o[18:0], lane_b_i};
        end
    end
endmodule

// ### tb/testbench.sv
/* Self-checking bench: APB register access and serial output checks.
   Assumes adc_path_config with 18-bit samples and lvds_receiver. */
`timescale 1ns/100ps
module testbench;
    import adc_path_pkg::*;
    localparam logic [17:0] VAL_A = 18'h12345;
    localparam logic [17:0] VAL_B = 18'h0ABCD;
    logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, sample_clk;
    logic [9:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [17:0] sample_a, sample_b;
    logic bclk, frame_clock, lane_a, lane_b;
    logic [1:0] dtrim, ctrim;
    logic [19:0] fw, aw, bw;
    int num_errors = 0;
    int checks_done = 0;
    wire logic [18:0] sum_ab = VAL_A + VAL_B;
    wire logic [17:0] avg_ab = sum_ab[18:1];

    adc_path_config u_adc_path_config (.ref_clk_i(ref_clk), .reset_i(reset), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .sample_clk_i(sample_clk), .sample_a_i(sample_a),
        .sample_b_i(sample_b), .output_bit_clock_o(bclk), .frame_clock_o(frame_clock), .lane_a_o(lane_a),
        .lane_b_o(lane_b), .data_timing_trim_o(dtrim), .bit_clock_timing_trim_o(ctrim));
    lvds_receiver u_lvds_receiver (.ref_clk_i(ref_clk), .reset_i(reset), .bit_clock_i(bclk),
        .frame_i(frame_clock), .lane_a_i(lane_a), .lane_b_i(lane_b), .frame_word_o(fw),
        .lane_a_word_o(aw), .lane_b_word_o(bw));

    always #2.5 ref_clk = ~ref_clk;
    always #40 sample_clk = ~sample_clk;

    ////////////////////////////////////////////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL t=%0t got %h expected %h", $time, seen, exp);
        end
    endtask

    // Request held until pready is seen at a rising edge; only the watchdog ends a hang
    task apb(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] i, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, {i, 2'h0}, d, r, e);
    endtask

    task rd_chk(input logic [7:0] i, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, {i, 2'h0}, 32'h0, r, e);
        check(r, x);
    endtask

    // Settle, then find the frame pattern at word alignment
    task word(input logic [19:0] pat, input int settle);
        int n;
        repeat (settle) @(posedge ref_clk);
        n = 0;
        while (fw !== pat && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        check(fw, pat);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task test_reset;
        logic [31:0] r;
        logic e;
        rd_chk(IDX_TIMING_TRIM, 32'h0);
        rd_chk(IDX_FRAME_LOW, 32'h0);
        rd_chk(IDX_FRAME_MID, 32'hFC);
        rd_chk(IDX_FRAME_HIGH, 32'h0F);
        rd_chk(IDX_PATH_CTRL, 32'h0);
        rd_chk(IDX_DECIM_CTRL, 32'h0);
        apb(1'b0, 10'h3FC, 32'h0, r, e);
        check(r, 32'h0);
        check({31'h0, e}, 32'h1);
        apb(1'b1, 10'h079, 32'hFF, r, e);
        check({31'h0, e}, 32'h1);
        rd_chk(IDX_TIMING_TRIM, 32'h0);
        $display("test reset done");
    endtask

    task test_trim;
        for (int i = 0; i < 4; i++) begin
            wr(IDX_TIMING_TRIM, {28'h0, i[1:0], ~i[1:0]});
            repeat (2) @(posedge ref_clk);
            check({dtrim, ctrim}, {i[1:0], ~i[1:0]});
        end
        wr(IDX_TIMING_TRIM, 32'hFF);
        rd_chk(IDX_TIMING_TRIM, 32'h0F);
        $display("test trim done");
    endtask

    task test_mux;
        logic [17:0] ea [5];
        logic [17:0] eb [5];
        ea = '{VAL_A, VAL_A, VAL_B, avg_ab, VAL_A};
        eb = '{VAL_B, VAL_A, VAL_B, avg_ab, VAL_B};
        wr(IDX_FRAME_HIGH, 32'h0F);
        for (int c = 0; c < 5; c++) begin
            wr(IDX_PATH_CTRL, {26'h0, c == 3, c[1:0] | (c == 4), 3'h6});
            wr(IDX_DECIM_CTRL, {24'h0, c < 4, 7'h08});
            word(20'hFFC00, 400);
            check({aw, bw}, {ea[c], 2'h0, eb[c], 2'h0});
        end
        $display("test mux done");
    endtask

    task test_bypass;
        wr(IDX_FRAME_LOW, 32'hFF);
        wr(IDX_FRAME_MID, 32'hFF);
        wr(IDX_FRAME_HIGH, 32'h4F);
        wr(IDX_PATH_CTRL, 32'h08);
        wr(IDX_DECIM_CTRL, 32'h98);
        word(20'hFFC00, 400);
        check({aw, bw}, {VAL_A, 2'h0, VAL_B, 2'h0});
        wr(IDX_PATH_CTRL, 32'h06);
        wr(IDX_DECIM_CTRL, 32'h08);
        word(20'hFFC00, 400);
        check(aw !== {VAL_A, 2'h0}, 1'b1);
        check(aw[19:15], VAL_A[17:13]);
        $display("test bypass done");
    endtask

    task test_decim;
        logic [19:0] t;
        wr(IDX_NCO_FREQ, 32'h1234_5678);
        rd_chk(IDX_NCO_FREQ, 32'h1234_5678);
        wr(IDX_NCO_FREQ, 32'h0000_0000);
        wr(IDX_FRAME_LOW, 32'h00);
        wr(IDX_FRAME_MID, 32'hF8);
        wr(IDX_FRAME_HIGH, 32'h0F);
        for (int r = 1; r < 6; r++) begin
            wr(IDX_DECIM_CTRL, {25'h0, r[2:0], 4'h8});
            rd_chk(IDX_DECIM_CTRL, {25'h0, r[2:0], 4'h8});
            word(20'hFF800, 1500);
            check(aw, {VAL_A, 2'h0});
        end
        // Zero frequency, inverted phase: I word is A and Q word is -A
        wr(IDX_FRAME_MID, 32'hFC);
        wr(IDX_DECIM_CTRL, 32'h11);
        word(20'hFFC00, 1000);
        t = aw;
        word(20'hFFC00, 8);
        check({14'h0, 18'(t[19:2] + aw[19:2])}, 32'h0);
        wr(IDX_FRAME_MID, 32'hF8);
        wr(IDX_PATH_CTRL, 32'h04);
        word(20'hFFC00, 400);
        $display("test decimation done");
    endtask

    task complete_run;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        sample_clk = 1'b0;
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 10'h0;
        pwdata = 32'h0;
        sample_a = VAL_A;
        sample_b = VAL_B;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        test_reset;
        test_trim;
        test_mux;
        test_bypass;
        test_decim;
        complete_run;
    end

    // Whole run needs about 12500 cycles
    initial begin
        #400000;
        num_errors++;
        complete_run;
    end
endmodule
